// file: fpe_cfg.svh
// register map, field positions, reset values and timing for the flash control block
// assumes inclusion by the package and the design modules
`ifndef FPE_CFG_SVH
`define FPE_CFG_SVH
`define FPE_ADDR_W 3
`define FPE_OFS_MODE 3'h0
`define FPE_OFS_STAT 3'h1
`define FPE_OFS_EBS 3'h2
`define FPE_OFS_PWR 3'h3
`define FPE_OFS_GATE 3'h4
`define FPE_OFS_IOCTL 3'h5
`define FPE_MODE_SWE 6
`define FPE_MODE_ESU 5
`define FPE_MODE_PSU 4
`define FPE_MODE_EV 3
`define FPE_MODE_PV 2
`define FPE_MODE_E 1
`define FPE_MODE_P 0
`define FPE_STAT_FLT 7
`define FPE_PWR_INH 7
`define FPE_GATE_EN 7
`define FPE_GATE_RSV 6
`define FPE_IOCTL_FAIL 0
`define FPE_MODE_WMASK 8'h7f
`define FPE_RST_BYTE 8'h00
`define FPE_PROG_UNIT_BYTES 128
`define FPE_PROG_ALIGN_MASK 17'h0007f
`define FPE_ADDR_BITS 17
`define FPE_WAIT_CYC 1'b1
`endif

// file: fpe_pkg.sv
// types for the flash program and erase controller
// assumes fpe_cfg.svh is on the include path
`include "fpe_cfg.svh"
package fpe_pkg;
  typedef enum logic [4:0] {
    FPE_OP_IDLE = 5'h01,
    FPE_OP_PROG = 5'h02,
    FPE_OP_PVER = 5'h04,
    FPE_OP_ERAS = 5'h08,
    FPE_OP_EVER = 5'h10
  } fpe_op_t;
  typedef enum logic [1:0] {
    FPE_BUS_IDLE = 2'h1,
    FPE_BUS_RESP = 2'h2
  } fpe_bus_t;
endpackage

// file: fpe_pin_sync.sv
// three-stage synchroniser for an outside level; change counted once stages one and two agree
// assumes sys_clk domain and active-low async reset
`timescale 1ns/1ps
module fpe_pin_sync (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic pin_in,
  output logic level_out
);
  typedef struct packed {
    logic [2:0] stg;
    logic lvl;
  } fpe_sync_st_t;
  fpe_sync_st_t st_reg;
  fpe_sync_st_t st_next;
  always_comb begin
    st_next = st_reg;
    if (clk_en) begin
      st_next.stg = {st_reg.stg[1:0], pin_in};
      // stage 0 feeds only stage 1
      if (st_reg.stg[1] == st_reg.stg[2]) begin
        st_next.lvl = st_reg.stg[2];
      end
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign level_out = st_reg.lvl;
endmodule

// file: fpe_blk_decode.sv
// maps the one-hot erase select to block base address and size in kbytes
// assumes a registered select that is zero or one-hot
`timescale 1ns/1ps
module fpe_blk_decode (
  input wire logic [7:0] blk_sel,
  output logic [16:0] blk_base,
  output logic [5:0] blk_kbytes,
  output logic blk_valid
);
  localparam logic [16:0] BASES [8] = '{17'h18000, 17'h10000, 17'h08000, 17'h01000,
                                         17'h00c00, 17'h00800, 17'h00400, 17'h00000};
  localparam logic [5:0] SIZES [8] = '{6'h20, 6'h20, 6'h20, 6'h1c, 6'h01, 6'h01, 6'h01, 6'h01};
  logic [16:0] base_v [9];
  logic [5:0] size_v [9];
  assign base_v[0] = 17'h00000;
  assign size_v[0] = 6'h00;
  // eight blocks: four 1k, one 28k, three 32k
  for (genvar i = 0; i < 8; i++) begin : g_blk
    assign base_v[i+1] = blk_sel[i] ? BASES[7-i] : base_v[i];
    assign size_v[i+1] = blk_sel[i] ? SIZES[7-i] : size_v[i];
  end
  assign blk_base = base_v[8];
  assign blk_kbytes = size_v[8];
  assign blk_valid = |blk_sel;
endmodule

// file: fpe_flash_ctrl.sv
// flash program/erase control registers with Avalon-MM slave, block decode and power-down control
// assumes the cpu bus on sys_clk; subactive and op-fail come from outside and are synchronised
//
// The register addresses and the Avalon-MM register port were decided locally.
`timescale 1ns/1ps
`include "fpe_cfg.svh"
module fpe_flash_ctrl (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [`FPE_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic subactive_pin,
  input wire logic op_fail_pin,
  input wire logic [16:0] prog_addr,
  output logic prog_mode,
  output logic prog_verify_mode,
  output logic erase_mode,
  output logic erase_verify_mode,
  output logic fault_protect,
  output logic flash_power_down,
  output logic flash_read_ok,
  output logic [7:0] erase_blk_sel,
  output logic [16:0] erase_base,
  output logic [5:0] erase_kbytes,
  output logic prog_addr_ok
);
  typedef struct packed {
    fpe_pkg::fpe_bus_t bus;
    logic [31:0] rdata;
    logic [7:0] mode;
    logic flt;
    logic [7:0] ebs;
    logic inh;
    logic gate;
    logic gate_rsv;
    fpe_pkg::fpe_op_t op;
    logic pdn;
    logic [16:0] base;
    logic [5:0] kb;
    logic addr_ok;
  } fpe_state_t;
  fpe_state_t st_reg;
  fpe_state_t st_next;
  logic subact_s;
  logic fail_s;
  logic [16:0] dec_base;
  logic [5:0] dec_kb;
  logic [7:0] wbyte;
  logic [7:0] mode_w;
  logic [7:0] rbyte;
  logic acc;
  fpe_pin_sync u_sync_sub (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .pin_in(subactive_pin),
    .level_out(subact_s)
  );
  fpe_pin_sync u_sync_fail (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .pin_in(op_fail_pin),
    .level_out(fail_s)
  );
  fpe_blk_decode u_dec (
    .blk_sel(st_reg.ebs),
    .blk_base(dec_base),
    .blk_kbytes(dec_kb),
    .blk_valid()
  );
  always_comb begin
    st_next = st_reg;
    wbyte = avs_byteenable[0] ? avs_writedata[7:0] : `FPE_RST_BYTE;
    mode_w = st_reg.mode;
    rbyte = `FPE_RST_BYTE;
    acc = 1'b0;
    if (clk_en) begin
      case (st_reg.bus)
        fpe_pkg::FPE_BUS_IDLE: begin
          if (avs_read || avs_write) begin
            st_next.bus = fpe_pkg::FPE_BUS_RESP;
            // gated registers need the gate bit; the gate register itself is always open
            acc = st_reg.gate || (avs_address == `FPE_OFS_GATE);
            case (avs_address)
              `FPE_OFS_MODE: rbyte = st_reg.mode;
              `FPE_OFS_STAT: rbyte = {st_reg.flt, 7'h00};
              `FPE_OFS_EBS: rbyte = st_reg.ebs;
              `FPE_OFS_PWR: rbyte = {st_reg.inh, 7'h00};
              `FPE_OFS_GATE: rbyte = {st_reg.gate, st_reg.gate_rsv, 6'h00};
              default: rbyte = `FPE_RST_BYTE;
            endcase
            st_next.rdata = (avs_read && acc) ? {24'h000000, rbyte} : 32'h00000000;
            if (avs_write && acc && avs_byteenable[0]) begin
              case (avs_address)
                `FPE_OFS_MODE: begin
                  mode_w = wbyte & `FPE_MODE_WMASK;
                  if (!mode_w[`FPE_MODE_SWE]) begin
                    mode_w = `FPE_RST_BYTE;
                  end
                  // program and erase may not start from a setup-less or protected state
                  if (!st_reg.mode[`FPE_MODE_P] && !(mode_w[`FPE_MODE_PSU] && !st_reg.flt)) begin
                    mode_w[`FPE_MODE_P] = 1'b0;
                  end
                  if (!st_reg.mode[`FPE_MODE_E] && !(mode_w[`FPE_MODE_ESU] && !st_reg.flt)) begin
                    mode_w[`FPE_MODE_E] = 1'b0;
                  end
                  st_next.mode = mode_w;
                end
                `FPE_OFS_EBS: begin
                  if (st_reg.mode[`FPE_MODE_SWE]) begin
                    st_next.ebs = ($countones(wbyte) > 1) ? `FPE_RST_BYTE : wbyte;
                  end
                end
                `FPE_OFS_PWR: st_next.inh = wbyte[`FPE_PWR_INH];
                `FPE_OFS_GATE: begin
                  st_next.gate = wbyte[`FPE_GATE_EN];
                  st_next.gate_rsv = wbyte[`FPE_GATE_RSV];
                end
                default: st_next.gate = st_reg.gate; // status and unmapped writes ignored
              endcase
            end
          end
        end
        fpe_pkg::FPE_BUS_RESP: st_next.bus = fpe_pkg::FPE_BUS_IDLE;
        default: st_next.bus = fpe_pkg::FPE_BUS_IDLE;
      endcase
      if (!st_next.mode[`FPE_MODE_SWE]) begin
        st_next.ebs = `FPE_RST_BYTE;
      end
      // fault sticks until reset; set wins over any clear
      if (fail_s && (st_reg.mode[`FPE_MODE_P] || st_reg.mode[`FPE_MODE_E])) begin
        st_next.flt = 1'b1;
      end
      if (st_next.flt) begin
        st_next.mode[`FPE_MODE_P] = 1'b0;
        st_next.mode[`FPE_MODE_E] = 1'b0;
      end
      // priority keeps one operation at a time
      if (st_next.mode[`FPE_MODE_P]) begin
        st_next.op = fpe_pkg::FPE_OP_PROG;
      end else if (st_next.mode[`FPE_MODE_E]) begin
        st_next.op = fpe_pkg::FPE_OP_ERAS;
      end else if (st_next.mode[`FPE_MODE_PV]) begin
        st_next.op = fpe_pkg::FPE_OP_PVER;
      end else if (st_next.mode[`FPE_MODE_EV]) begin
        st_next.op = fpe_pkg::FPE_OP_EVER;
      end else begin
        st_next.op = fpe_pkg::FPE_OP_IDLE;
      end
      st_next.pdn = subact_s && !st_reg.inh;
      st_next.base = dec_base;
      st_next.kb = dec_kb;
      st_next.addr_ok = (prog_addr & `FPE_PROG_ALIGN_MASK) == 17'h00000;
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
      st_reg.bus <= fpe_pkg::FPE_BUS_IDLE;
      st_reg.op <= fpe_pkg::FPE_OP_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end
  assign avs_readdata = st_reg.rdata;
  // waitrequest is high except in the answer cycle
  assign avs_waitrequest = (st_reg.bus != fpe_pkg::FPE_BUS_RESP);
  assign prog_mode = st_reg.op == fpe_pkg::FPE_OP_PROG;
  assign prog_verify_mode = st_reg.op == fpe_pkg::FPE_OP_PVER;
  assign erase_mode = st_reg.op == fpe_pkg::FPE_OP_ERAS;
  assign erase_verify_mode = st_reg.op == fpe_pkg::FPE_OP_EVER;
  assign fault_protect = st_reg.flt;
  assign flash_power_down = st_reg.pdn;
  // reading stays allowed in power-down; only program/erase stop it
  assign flash_read_ok = (st_reg.op != fpe_pkg::FPE_OP_PROG) && (st_reg.op != fpe_pkg::FPE_OP_ERAS);
  assign erase_blk_sel = st_reg.ebs;
  assign erase_base = st_reg.base;
  assign erase_kbytes = st_reg.kb;
  assign prog_addr_ok = st_reg.addr_ok;

  a_ebs_onehot: assert property (@(posedge sys_clk) disable iff (!rst_n) $countones(st_reg.ebs) <= 1)
    else $error("erase select not one-hot");
  a_ebs_swe: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !st_reg.mode[`FPE_MODE_SWE] |-> st_reg.ebs == 8'h00)
    else $error("erase select set with write disabled");
  a_prog_needs_setup: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(st_reg.mode[`FPE_MODE_P]) |-> st_reg.mode[`FPE_MODE_SWE] && st_reg.mode[`FPE_MODE_PSU])
    else $error("program entered without setup");
  a_erase_needs_setup: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(st_reg.mode[`FPE_MODE_E]) |-> st_reg.mode[`FPE_MODE_SWE] && st_reg.mode[`FPE_MODE_ESU])
    else $error("erase entered without setup");
  a_fault_blocks: assert property (@(posedge sys_clk) disable iff (!rst_n)
    st_reg.flt |-> !prog_mode && !erase_mode)
    else $error("operation active under protection");
  a_fault_sticky: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $past(st_reg.flt) |-> st_reg.flt)
    else $error("fault flag cleared without reset");
  a_pv_mode: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && st_next.mode[`FPE_MODE_PV] && !st_next.mode[`FPE_MODE_P] && !st_next.mode[`FPE_MODE_E]
    |=> prog_verify_mode)
    else $error("verify bit not reflected");
  a_one_op: assert property (@(posedge sys_clk) disable iff (!rst_n) $onehot(st_reg.op))
    else $error("operation not one-hot");
  a_power_down: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && subact_s && !st_reg.inh |=> flash_power_down)
    else $error("power-down not entered");
  a_bus_answer: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !avs_waitrequest |=> avs_waitrequest)
    else $error("answer longer than one cycle");
  c_prog: cover property (@(posedge sys_clk) disable iff (!rst_n) $rose(prog_mode));
  c_erase: cover property (@(posedge sys_clk) disable iff (!rst_n) $rose(erase_mode));
  c_fault: cover property (@(posedge sys_clk) disable iff (!rst_n) $rose(fault_protect));
  c_pdn: cover property (@(posedge sys_clk) disable iff (!rst_n) $rose(flash_power_down));
endmodule

// file: fpe_tb.sv
// self-checking bench for the flash program/erase control block
// assumes fpe_flash_ctrl answers on the avalon slave one cycle after a take
`timescale 1ns/1ps
`include "fpe_cfg.svh"
module tb;
  logic sys_clk = 0, rst_n = 0, clk_en = 1, avs_read = 0, avs_write = 0;
  logic [`FPE_ADDR_W-1:0] avs_address = 0;
  logic [31:0] avs_writedata = 0, avs_readdata, rd;
  logic [3:0] avs_byteenable = 4'h1;
  logic avs_waitrequest, subactive_pin = 0, op_fail_pin = 0;
  logic [16:0] prog_addr = 0, erase_base;
  logic pm, pvm, em, evm, fp, pd, rok, pao;
  logic [7:0] ebs;
  logic [5:0] erase_kbytes;
  logic [7:0] mval [7] = '{8'h41, 8'h51, 8'h62, 8'h44, 8'h48, 8'h31, 8'h40};
  logic [3:0] mexp [7] = '{4'h0, 4'h8, 4'h2, 4'h4, 4'h1, 4'h0, 4'h0};
  int failures = 0, total_checks = 0, i, b, n;
  always #5 sys_clk = ~sys_clk;
  fpe_flash_ctrl dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .subactive_pin(subactive_pin),
    .op_fail_pin(op_fail_pin), .prog_addr(prog_addr), .prog_mode(pm), .prog_verify_mode(pvm), .erase_mode(em),
    .erase_verify_mode(evm), .fault_protect(fp), .flash_power_down(pd), .flash_read_ok(rok),
    .erase_blk_sel(ebs), .erase_base(erase_base), .erase_kbytes(erase_kbytes), .prog_addr_ok(pao));
  task automatic final_report;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one avalon transfer; held until the rising edge that samples waitrequest low
  task automatic bus(input logic wr, input logic [2:0] a, input logic [7:0] d);
    int k;
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= wr;
    avs_read <= !wr;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 50);
    if (avs_waitrequest !== 1'b0) begin
      failures++;
      final_report;
    end
    rd = avs_readdata;
    avs_read <= 0;
    avs_write <= 0;
  endtask
  task automatic settle;
    repeat (4) @(posedge sys_clk);
    #1;
  endtask
  function automatic logic [22:0] blk_exp(input int k);
    if (k < 4)
      return {17'(k * 1024), 6'h01};
    if (k == 4)
      return {17'h01000, 6'h1c};
    return {17'((k - 4) * 32'h8000), 6'h20};
  endfunction
  initial begin
    n = $urandom(81);
    repeat (20) @(posedge sys_clk);
    rst_n <= 1;
    #1;
    chk("waitrequest", avs_waitrequest, 1);
    // gate closed: offset 5 is unmapped, all read zero
    for (i = 0; i < 6; i++) begin
      bus(0, i, 0);
      chk("reset read", rd, 0);
    end
    bus(1, `FPE_OFS_MODE, 8'h40);
    bus(1, `FPE_OFS_GATE, 8'h80);
    bus(0, `FPE_OFS_MODE, 0);
    chk("gated mode", rd, 0);
    bus(0, `FPE_OFS_GATE, 0);
    chk("gate", rd, 32'h80);
    $display("test gate done");
    for (i = 0; i < 7; i++) begin
      bus(1, `FPE_OFS_MODE, mval[i]);
      settle;
      chk("modes", {pm, pvm, em, evm}, mexp[i]);
      chk("read ok", rok, !(pm | em));
    end
    $display("test modes done");
    bus(1, `FPE_OFS_MODE, 0);
    bus(1, `FPE_OFS_EBS, 8'h01);
    bus(0, `FPE_OFS_EBS, 0);
    chk("ebs off", rd, 0);
    bus(1, `FPE_OFS_MODE, 8'h40);
    b = $urandom % 8;
    for (i = 0; i < 8; i++) begin
      bus(1, `FPE_OFS_EBS, 8'h01 << ((i + b) % 8));
      settle;
      chk("ebs", ebs, 8'h01 << ((i + b) % 8));
      chk("blk", {erase_base, erase_kbytes}, blk_exp((i + b) % 8));
    end
    bus(1, `FPE_OFS_EBS, 8'h03 | 8'($urandom));
    bus(0, `FPE_OFS_EBS, 0);
    chk("ebs multi", rd, 0);
    bus(1, `FPE_OFS_EBS, 8'h10);
    bus(1, `FPE_OFS_MODE, 0);
    settle;
    chk("ebs swe", ebs, 0);
    bus(1, `FPE_OFS_STAT, 8'hff);
    bus(0, `FPE_OFS_STAT, 0);
    chk("status", rd, 0);
    $display("test select done");
    bus(1, `FPE_OFS_PWR, 8'hff);
    bus(0, `FPE_OFS_PWR, 0);
    chk("power reg", rd, 32'h80);
    subactive_pin <= 1;
    settle;
    settle;
    chk("pd inhibit", pd, 0);
    bus(1, `FPE_OFS_PWR, 0);
    settle;
    chk("pd", pd, 1);
    chk("pd read ok", rok, 1);
    subactive_pin <= 0;
    $display("test power done");
    // low byte 0x00 and 0x80 as corners, then random addresses
    for (i = 0; i < 20; i++) begin
      @(posedge sys_clk);
      prog_addr <= (i < 2) ? 17'(i * 32'h80) : 17'($urandom);
      settle;
      chk("unit align", pao, prog_addr[6:0] == 7'h00);
    end
    bus(1, `FPE_OFS_MODE, 8'h50);
    bus(1, `FPE_OFS_MODE, 8'h51);
    op_fail_pin <= 1;
    for (n = 0; n < 50 && fp !== 1'b1; n++)
      @(negedge sys_clk);
    chk("fault", fp, 1);
    if (fp !== 1'b1) begin
      final_report;
    end
    settle;
    chk("prog stop", pm, 0);
    bus(0, `FPE_OFS_STAT, 0);
    chk("status flt", rd, 32'h80);
    op_fail_pin <= 0;
    bus(1, `FPE_OFS_MODE, 8'h51);
    bus(1, `FPE_OFS_MODE, 8'h62);
    settle;
    chk("protect", {pm, em, fp}, 3'h1);
    $display("test fault done");
    final_report;
  end
endmodule
